// *** rtl/raster_timing_regs.vh ***
// Register indices, control fields and reset values of the raster timing block
`ifndef RASTER_TIMING_REGS_VH
`define RASTER_TIMING_REGS_VH

// Register indices; byte address is four times the index
`define IDX_SCREEN_X_START 6'h01
`define IDX_SCREEN_Y_START 6'h02
`define IDX_SCREEN_X_END 6'h03
`define IDX_SCREEN_Y_END 6'h04
`define IDX_VERT_SYNC_WIDTH 6'h05
`define IDX_VERT_DELAY_FIRST 6'h06
`define IDX_VERT_DELAY_SECOND 6'h07
`define IDX_VERT_ACTIVE_LINES 6'h08
`define IDX_VERT_TOTAL_COUNT 6'h09
`define IDX_HORIZ_SYNC_WIDTH 6'h0A
`define IDX_HORIZ_SCAN_DELAY 6'h0B
`define IDX_HORIZ_ACTIVE_COUNT 6'h0C
`define IDX_HORIZ_TOTAL_COUNT 6'h0D
`define IDX_WINDOW_SCREEN_X_START 6'h0E
`define IDX_WINDOW_SCREEN_Y_START 6'h0F
`define IDX_WINDOW_SCREEN_X_END 6'h10
`define IDX_WINDOW_SCREEN_Y_END 6'h11
`define IDX_WINDOW_SOURCE_X 6'h12
`define IDX_WINDOW_SOURCE_Y 6'h13
`define IDX_CONTROL 6'h1C
`define IDX_STATUS 6'h1D

// Control register fields
`define CTRL_TIMING_ENABLE 0
`define CTRL_HORIZ_MASTER 1
`define CTRL_VERT_MASTER 2
`define CTRL_INTERLACED 3

// Status register fields
`define STAT_FRAME_RELOAD 0
`define STAT_RUNNING 1
`define STAT_SECOND_FIELD 2
`define STAT_VERT_BLANKING 3

// Reset values
`define RST_COORD 12'h000
`define RST_CONTROL 4'h6

// Coordinate width
`define COORD_W 12

`endif

// *** rtl/pin_fall_detect.v ***
// Two-stage synchroniser with falling-edge pulse for an active-low pin
module pin_fall_detect (
  input wire mclk,
  input wire rst_n,
  input wire pin_n,
  output wire level_n,
  output wire fall
);

  reg meta;
  reg stable;
  reg prev;

  always @(posedge mclk) begin
    if (!rst_n) begin
      meta <= 1'b1;
      stable <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin_n;
      stable <= meta;
      prev <= stable;
    end
  end

  assign level_n = stable;
  assign fall = prev & ~stable;

endmodule // pin_fall_detect

// *** rtl/span_gen.v ***
// Sync and active-span decode of one raster counter
module span_gen #(
  parameter W = 10
) (
  input wire [W-1:0] cnt,
  input wire [W-1:0] sync_len,
  input wire [W-1:0] delay,
  input wire [W-1:0] active_len,
  output wire sync,
  output wire active
);

  wire [W-1:0] active_end;

  assign active_end = delay + active_len;
  // Sync may outlast the start of the active span (negative back porch)
  assign sync = cnt < sync_len;
  assign active = (cnt >= delay) && (cnt < active_end);

endmodule // span_gen

// *** rtl/raster_timing.v ***
// Raster timing generator with screen and window coordinate registers
`include "raster_timing_regs.vh"

module raster_timing #(
  parameter PIX_SHIFT = 4
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire horiz_slave_reset_in_n,
  input wire vert_slave_reset_in_n,
  output reg horiz_sync,
  output reg vert_sync,
  output reg second_field,
  output reg frame_reload_irq,
  output reg fetch_valid,
  output reg [11:0] fetch_x,
  output reg [11:0] fetch_y
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg [11:0] screen_x_start;
  reg [11:0] screen_y_start;
  reg [11:0] screen_x_end;
  reg [11:0] screen_y_end;
  reg [11:0] window_screen_x_start;
  reg [11:0] window_screen_y_start;
  reg [11:0] window_screen_x_end;
  reg [11:0] window_screen_y_end;
  reg [11:0] window_source_x;
  reg [11:0] window_source_y;
  reg [7:0] horiz_sync_width;
  reg [6:0] horiz_scan_delay;
  reg [7:0] horiz_active_count;
  reg [8:0] horiz_total_count;
  reg [9:0] vert_sync_width;
  reg [9:0] vert_delay_first_field;
  reg [9:0] vert_delay_second_field;
  reg [10:0] vert_active_lines;
  reg [12:0] vert_total_count;
  reg [3:0] control;
  reg running;
  reg vert_blank;

  wire [5:0] idx;
  wire req;
  wire wr;
  reg [15:0] cur_val;
  reg readable;
  wire [15:0] wmerge;
  wire [31:0] next_dat;

  assign idx = adr_i[7:2];
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i;

  // Current value of the addressed register, used for byte-lane merging
  always @* begin
    cur_val = 16'h0000;
    readable = 1'b1;
    case (idx)
      `IDX_SCREEN_X_START: cur_val = {4'h0, screen_x_start};
      `IDX_SCREEN_Y_START: cur_val = {4'h0, screen_y_start};
      `IDX_SCREEN_X_END: cur_val = {4'h0, screen_x_end};
      `IDX_SCREEN_Y_END: cur_val = {4'h0, screen_y_end};
      `IDX_WINDOW_SCREEN_X_START: cur_val = {4'h0, window_screen_x_start};
      `IDX_WINDOW_SCREEN_Y_START: cur_val = {4'h0, window_screen_y_start};
      `IDX_WINDOW_SCREEN_X_END: cur_val = {4'h0, window_screen_x_end};
      `IDX_WINDOW_SCREEN_Y_END: cur_val = {4'h0, window_screen_y_end};
      `IDX_WINDOW_SOURCE_X: cur_val = {4'h0, window_source_x};
      `IDX_WINDOW_SOURCE_Y: cur_val = {4'h0, window_source_y};
      `IDX_CONTROL: cur_val = {12'h000, control};
      `IDX_STATUS: cur_val = {12'h000, vert_blank, second_field, running, frame_reload_irq};
      `IDX_HORIZ_SYNC_WIDTH: begin
        cur_val = {8'h00, horiz_sync_width};
        readable = 1'b0;
      end
      `IDX_HORIZ_SCAN_DELAY: begin
        cur_val = {9'h000, horiz_scan_delay};
        readable = 1'b0;
      end
      `IDX_HORIZ_ACTIVE_COUNT: begin
        cur_val = {8'h00, horiz_active_count};
        readable = 1'b0;
      end
      `IDX_HORIZ_TOTAL_COUNT: begin
        cur_val = {7'h00, horiz_total_count};
        readable = 1'b0;
      end
      `IDX_VERT_SYNC_WIDTH: begin
        cur_val = {6'h00, vert_sync_width};
        readable = 1'b0;
      end
      `IDX_VERT_DELAY_FIRST: begin
        cur_val = {6'h00, vert_delay_first_field};
        readable = 1'b0;
      end
      `IDX_VERT_DELAY_SECOND: begin
        cur_val = {6'h00, vert_delay_second_field};
        readable = 1'b0;
      end
      `IDX_VERT_ACTIVE_LINES: begin
        cur_val = {5'h00, vert_active_lines};
        readable = 1'b0;
      end
      `IDX_VERT_TOTAL_COUNT: begin
        cur_val = {3'h0, vert_total_count};
        readable = 1'b0;
      end
      default: readable = 1'b0;
    endcase
  end

  assign wmerge = {sel_i[1] ? dat_i[15:8] : cur_val[15:8], sel_i[0] ? dat_i[7:0] : cur_val[7:0]};
  // Screen and window registers read back; timing registers read zero
  assign next_dat = readable ? {16'h0000, cur_val} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one-cycle registered acknowledge for every address

  always @(posedge mclk) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (req) begin
        dat_o <= next_dat;
      end
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      screen_x_start <= `RST_COORD;
      screen_y_start <= `RST_COORD;
      screen_x_end <= `RST_COORD;
      screen_y_end <= `RST_COORD;
      window_screen_x_start <= `RST_COORD;
      window_screen_y_start <= `RST_COORD;
      window_screen_x_end <= `RST_COORD;
      window_screen_y_end <= `RST_COORD;
      window_source_x <= `RST_COORD;
      window_source_y <= `RST_COORD;
      horiz_sync_width <= 8'h00;
      horiz_scan_delay <= 7'h00;
      horiz_active_count <= 8'h00;
      horiz_total_count <= 9'h000;
      vert_sync_width <= 10'h000;
      vert_delay_first_field <= 10'h000;
      vert_delay_second_field <= 10'h000;
      vert_active_lines <= 11'h000;
      vert_total_count <= 13'h0000;
      control <= `RST_CONTROL;
    end else if (wr) begin
      case (idx)
        `IDX_SCREEN_X_START: screen_x_start <= wmerge[11:0];
        `IDX_SCREEN_Y_START: screen_y_start <= wmerge[11:0];
        `IDX_SCREEN_X_END: screen_x_end <= wmerge[11:0];
        `IDX_SCREEN_Y_END: screen_y_end <= wmerge[11:0];
        `IDX_WINDOW_SCREEN_X_START: window_screen_x_start <= wmerge[11:0];
        `IDX_WINDOW_SCREEN_Y_START: window_screen_y_start <= wmerge[11:0];
        `IDX_WINDOW_SCREEN_X_END: window_screen_x_end <= wmerge[11:0];
        `IDX_WINDOW_SCREEN_Y_END: window_screen_y_end <= wmerge[11:0];
        `IDX_WINDOW_SOURCE_X: window_source_x <= wmerge[11:0];
        `IDX_WINDOW_SOURCE_Y: window_source_y <= wmerge[11:0];
        `IDX_HORIZ_SYNC_WIDTH: horiz_sync_width <= wmerge[7:0];
        `IDX_HORIZ_SCAN_DELAY: horiz_scan_delay <= wmerge[6:0];
        `IDX_HORIZ_ACTIVE_COUNT: horiz_active_count <= wmerge[7:0];
        `IDX_HORIZ_TOTAL_COUNT: horiz_total_count <= wmerge[8:0];
        `IDX_VERT_SYNC_WIDTH: vert_sync_width <= wmerge[9:0];
        `IDX_VERT_DELAY_FIRST: vert_delay_first_field <= wmerge[9:0];
        `IDX_VERT_DELAY_SECOND: vert_delay_second_field <= wmerge[9:0];
        `IDX_VERT_ACTIVE_LINES: vert_active_lines <= wmerge[10:0];
        `IDX_VERT_TOTAL_COUNT: vert_total_count <= wmerge[12:0];
        `IDX_CONTROL: control <= wmerge[3:0];
        default: control <= control;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave reset pins

  wire hres_fall;
  wire vres_fall;

  pin_fall_detect u_hres (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_n(horiz_slave_reset_in_n),
    .level_n(),
    .fall(hres_fall)
  );

  pin_fall_detect u_vres (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_n(vert_slave_reset_in_n),
    .level_n(),
    .fall(vres_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Raster counters

  reg [8:0] hcnt;
  reg [8:0] line_len;
  reg [12:0] vcnt;
  wire h_master;
  wire v_master;
  wire interlaced;
  wire line_end;
  wire half_tick;
  wire frame_end;
  wire [8:0] master_last;
  wire [12:0] vert_last;

  assign h_master = control[`CTRL_HORIZ_MASTER];
  assign v_master = control[`CTRL_VERT_MASTER];
  assign interlaced = control[`CTRL_INTERLACED];
  assign master_last = horiz_total_count - 9'h001;
  assign vert_last = vert_total_count - 13'h0001;
  // Master wraps on its total, slave only on the external reset
  assign line_end = h_master ? (hcnt == master_last) : hres_fall;
  // Half-line points fall at line start and mid-line; tick one count early so halves are equal
  assign half_tick = running & (line_end
                     | (hcnt == ({1'b0, line_len[8:1]} - 9'h001)));
  assign frame_end = v_master ? (half_tick & (vcnt == vert_last)) : vres_fall;

  always @(posedge mclk) begin
    if (!rst_n) begin
      running <= 1'b0;
      hcnt <= 9'h000;
      vcnt <= 13'h0000;
      line_len <= 9'h000;
      second_field <= 1'b0;
    end else begin
      if (!running) begin
        running <= control[`CTRL_TIMING_ENABLE];
        hcnt <= 9'h000;
        vcnt <= 13'h0000;
        second_field <= 1'b0;
      end else begin
        // Horizontal counter counts video clocks, each holding 2^PIX_SHIFT pixels; vertical counter counts half-lines
        if (line_end) begin
          hcnt <= 9'h000;
        end else begin
          hcnt <= hcnt + 9'h001;
        end
        if (!h_master && hres_fall) begin
          line_len <= hcnt + 9'h001;
        end else if (h_master) begin
          line_len <= horiz_total_count;
        end
        if (frame_end) begin
          vcnt <= 13'h0000;
          second_field <= interlaced & ~second_field;
          // A cleared enable stops timing only at the end of the frame
          running <= control[`CTRL_TIMING_ENABLE];
        end else if (half_tick) begin
          vcnt <= vcnt + 13'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync and blanking decode

  wire h_sync_c;
  wire h_act_c;
  wire v_sync_c;
  wire v_act_c;
  wire [9:0] v_delay;
  reg horiz_blanking;

  // Second-field delay only used when interlaced
  assign v_delay = (interlaced && second_field) ? vert_delay_second_field
                                                : vert_delay_first_field;

  span_gen #(
    .W(10)
  ) u_hspan (
    .cnt({1'b0, hcnt}),
    .sync_len({2'b00, horiz_sync_width}),
    .delay({3'b000, horiz_scan_delay}),
    .active_len({2'b00, horiz_active_count}),
    .sync(h_sync_c),
    .active(h_act_c)
  );

  span_gen #(
    .W(14)
  ) u_vspan (
    .cnt({1'b0, vcnt}),
    .sync_len({4'h0, vert_sync_width}),
    .delay({4'h0, v_delay}),
    .active_len({2'b00, vert_active_lines, 1'b0}),
    .sync(v_sync_c),
    .active(v_act_c)
  );

  always @(posedge mclk) begin
    if (!rst_n) begin
      horiz_sync <= 1'b0;
      vert_sync <= 1'b0;
      horiz_blanking <= 1'b1;
      vert_blank <= 1'b1;
    end else begin
      horiz_sync <= running & h_sync_c;
      vert_sync <= running & v_sync_c;
      horiz_blanking <= ~(running & h_act_c);
      vert_blank <= ~(running & v_act_c);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-frame copy of screen and window registers

  wire [119:0] shadow;
  reg [119:0] live;
  wire [11:0] l_sxs;
  wire [11:0] l_sys;
  wire [11:0] l_sxe;
  wire [11:0] l_sye;
  wire [11:0] l_wxs;
  wire [11:0] l_wys;
  wire [11:0] l_wxe;
  wire [11:0] l_wye;
  wire [11:0] l_rx;
  wire [11:0] l_ry;

  assign shadow = {screen_x_start, screen_y_start, screen_x_end, screen_y_end,
                   window_screen_x_start, window_screen_y_start, window_screen_x_end,
                   window_screen_y_end, window_source_x, window_source_y};
  assign {l_sxs, l_sys, l_sxe, l_sye, l_wxs, l_wys, l_wxe, l_wye, l_rx, l_ry} = live;

  always @(posedge mclk) begin
    if (!rst_n) begin
      live <= 120'h0;
      frame_reload_irq <= 1'b0;
    end else begin
      if (frame_end | ~running) begin
        live <= shadow;
      end
      // Set wins over a same-cycle write-one clear
      if (running & frame_end) begin
        frame_reload_irq <= 1'b1;
      end else if (wr && idx == `IDX_STATUS && sel_i[0] && dat_i[`STAT_FRAME_RELOAD]) begin
        frame_reload_irq <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display memory fetch address

  wire [8:0] hpos;
  wire [12:0] vpos;
  wire [11:0] xpix;
  wire [11:0] ypix;
  wire in_screen;
  wire in_window;

  assign hpos = hcnt - {2'b00, horiz_scan_delay};
  assign vpos = vcnt - {3'b000, v_delay};
  assign xpix = l_sxs + ({3'b000, hpos} << PIX_SHIFT);
  assign ypix = l_sys + vpos[12:1];
  // End pair is exclusive in both axes
  assign in_screen = (xpix < l_sxe) && (ypix < l_sye);
  // Window extent comes from apparent corners only
  assign in_window = (xpix >= l_wxs) && (xpix < l_wxe)
                     && (ypix >= l_wys) && (ypix < l_wye);

  always @(posedge mclk) begin
    if (!rst_n) begin
      fetch_valid <= 1'b0;
      fetch_x <= 12'h000;
      fetch_y <= 12'h000;
    end else begin
      fetch_valid <= running & h_act_c & v_act_c & in_screen;
      if (in_window) begin
        fetch_x <= l_rx + (xpix - l_wxs);
        fetch_y <= l_ry + (ypix - l_wys);
      end else begin
        fetch_x <= xpix;
        fetch_y <= ypix;
      end
    end
  end

endmodule // raster_timing

// *** test/raster_timing_properties.sv ***
// Concurrent checks on the bus and reload ports of the raster timing block
module raster_timing_properties #(
  parameter PIX_SHIFT = 4
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire frame_reload_irq,
  input wire fetch_valid
);
  wire req = cyc_i && stb_i && !ack_o;
  wire wo_rd = req && !we_i && adr_i[7:2] >= 6'h05 && adr_i[7:2] <= 6'h0D;
  wire irq_clr = req && we_i && adr_i[7:2] == 6'h1D && sel_i[0] && dat_i[0];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  chk_ack_answer: assert property (req |=> ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chk_read_width: assert property (ack_o |-> dat_o[31:12] == 20'h00000)
    else $error("read data wider than the register");
  chk_wo_zero: assert property (wo_rd |=> dat_o == 32'h00000000)
    else $error("timing register readable");
  chk_dat_hold: assert property (!req |=> $stable(dat_o))
    else $error("read data changed without request");
  chk_irq_sticky: assert property (frame_reload_irq && !irq_clr |=> frame_reload_irq)
    else $error("reload flag dropped without clear");
  chk_reload_blank: assert property ($rose(frame_reload_irq) |-> !fetch_valid)
    else $error("reload flag raised inside visible area");
endmodule // raster_timing_properties

bind raster_timing raster_timing_properties #(.PIX_SHIFT(PIX_SHIFT)) i_props (
  .mclk(mclk), .rst_n(rst_n), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .frame_reload_irq(frame_reload_irq), .fetch_valid(fetch_valid)
);

// *** test/sync_monitor.sv ***
// Monitor model: measures sync pulses, pulses the horizontal slave reset pin and holds the vertical one high
module sync_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic horiz_sync,
  input wire logic vert_sync,
  input wire logic [7:0] slave_period,
  output logic horiz_slave_reset_in_n,
  output wire logic vert_slave_reset_in_n,
  output logic [15:0] h_period,
  output logic [15:0] h_width,
  output logic [15:0] v_period,
  output logic [15:0] v_width
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hc, hw, vc, vw;
  logic [7:0] pc;
  logic hs_d, vs_d;
  assign vert_slave_reset_in_n = 1'b1;
  initial horiz_slave_reset_in_n = 1'b1;
  always @(posedge mclk) begin
    if (!rst_n) begin
      {hc, hw, vc, vw, h_period, h_width, v_period, v_width} <= '0;
      {hs_d, vs_d, pc} <= '0;
      horiz_slave_reset_in_n <= 1'b1;
    end else begin
      hs_d <= horiz_sync;
      vs_d <= vert_sync;
      hc <= hc + 16'h0001;
      vc <= vc + 16'h0001;
      hw <= hw + {15'h0000, horiz_sync};
      vw <= vw + {15'h0000, vert_sync};
      if (horiz_sync && !hs_d) begin
        h_period <= hc;
        hc <= 16'h0001;
        hw <= 16'h0001;
      end
      if (!horiz_sync && hs_d) h_width <= hw;
      if (vert_sync && !vs_d) begin
        v_period <= vc;
        vc <= 16'h0001;
        vw <= 16'h0001;
      end
      if (!vert_sync && vs_d) v_width <= vw;
      // One-cycle low pulse per period, shorter than any programmed sync
      if (slave_period == 8'h00) begin
        pc <= 8'h00;
        horiz_slave_reset_in_n <= 1'b1;
      end else begin
        pc <= (pc + 8'h01 == slave_period) ? 8'h00 : pc + 8'h01;
        horiz_slave_reset_in_n <= (pc != 8'h00);
      end
    end
  end
endmodule // sync_monitor

// *** test/raster_timing_test.sv ***
// Self-checking testbench of the raster timing block
`include "raster_timing_regs.vh"
module raster_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h00000000;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [7:0] slave_period = 8'h00;
  logic [31:0] dat_o, rd;
  logic ack_o, hrst_n, vrst_n, horiz_sync, vert_sync, second_field, frame_reload_irq;
  logic fetch_valid;
  logic [11:0] fetch_x, fetch_y;
  logic [15:0] h_period, h_width, v_period, v_width;
  int fail_count = 0;
  int checked = 0;
  logic [5:0] cfg_idx [12] = '{6'h05, 6'h06, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
    6'h01, 6'h02, 6'h03, 6'h04};
  logic [15:0] cfg_val [12] = '{16'h0002, 16'h0004, 16'h0002, 16'h000C, 16'h0002, 16'h0003,
    16'h0002, 16'h0008, 16'h0020, 16'h0010, 16'h0040, 16'h0012};
  always #12.5 mclk = ~mclk;
  raster_timing #(.PIX_SHIFT(4)) i_dut (.mclk(mclk), .rst_n(rst_n), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .horiz_slave_reset_in_n(hrst_n), .vert_slave_reset_in_n(vrst_n),
    .horiz_sync(horiz_sync), .vert_sync(vert_sync), .second_field(second_field),
    .frame_reload_irq(frame_reload_irq), .fetch_valid(fetch_valid), .fetch_x(fetch_x),
    .fetch_y(fetch_y));
  sync_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .horiz_sync(horiz_sync),
    .vert_sync(vert_sync), .slave_period(slave_period), .horiz_slave_reset_in_n(hrst_n),
    .vert_slave_reset_in_n(vrst_n), .h_period(h_period), .h_width(h_width),
    .v_period(v_period), .v_width(v_width));
  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task bus(input logic [5:0] idx, input logic we, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    {cyc_i, stb_i, we_i, sel_i} <= {2'b11, we, 4'h3};
    adr_i <= {idx, 2'b00};
    dat_i <= wd;
    @(posedge mclk);
    for (n = 1; n < 20 && ack_o !== 1'b1; n++) @(posedge mclk);
    if (n >= 20) begin
      fail_count++;
      wrap_up;
    end
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  // Clears the reload flag, then waits for the next frame copy
  task next_frame;
    int n;
    bus(`IDX_STATUS, 1'b1, 32'h00000001);
    for (n = 0; n < 800 && frame_reload_irq !== 1'b1; n++) @(posedge mclk);
    if (n >= 800) begin
      fail_count++;
      wrap_up;
    end
  endtask
  task capture(input logic [47:0] ex, input logic [47:0] ey);
    int k, n;
    k = 0;
    for (n = 0; n < 200 && k < 4; n++) begin
      @(posedge mclk);
      if (fetch_valid === 1'b1) begin
        check(32'(fetch_x), 32'(ex[47-12*k -: 12]));
        check(32'(fetch_y), 32'(ey[47-12*k -: 12]));
        k++;
      end
    end
    if (k < 4) check(32'(k), 32'h4);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    int i;
    bus(`IDX_SCREEN_X_START, 1'b1, 32'h0000FFFF);
    bus(`IDX_SCREEN_X_START, 1'b0, 32'h0);
    check(rd, 32'h00000FFF);
    for (i = 0; i < 6; i++) bus(6'h0E + 6'(i), 1'b1, 32'h100 + i);
    for (i = 0; i < 6; i++) begin
      bus(6'h0E + 6'(i), 1'b0, 32'h0);
      check(rd, 32'h100 + i);
      bus(6'h0E + 6'(i), 1'b1, 32'h0);
    end
    bus(`IDX_HORIZ_TOTAL_COUNT, 1'b1, 32'h00000008);
    bus(`IDX_HORIZ_TOTAL_COUNT, 1'b0, 32'h0);
    check(rd, 32'h00000000);
    bus(6'h3F, 1'b0, 32'h0);
    check(rd, 32'h00000000);
    $display("t_regs done");
  endtask
  task t_master;
    int i;
    for (i = 0; i < 12; i++) bus(cfg_idx[i], 1'b1, {16'h0000, cfg_val[i]});
    bus(`IDX_CONTROL, 1'b1, 32'h00000007);
    next_frame;
    next_frame;
    next_frame;
    check(32'(h_period), 32'h8);
    check(32'(h_width), 32'h2);
    check(32'(v_width), 32'h8);
    check(32'(v_period), 32'h30);
    check(32'(second_field), 32'h0);
    capture(48'h020030020030, 48'h010010011011);
    $display("t_master done");
  endtask
  task t_window;
    bus(`IDX_SCREEN_X_START, 1'b1, 32'h00000040);
    bus(`IDX_SCREEN_X_END, 1'b1, 32'h00000060);
    next_frame;
    capture(48'h040050040050, 48'h010010011011);
    bus(`IDX_WINDOW_SCREEN_X_START, 1'b1, 32'h00000050);
    bus(`IDX_WINDOW_SCREEN_Y_START, 1'b1, 32'h00000010);
    bus(`IDX_WINDOW_SCREEN_X_END, 1'b1, 32'h00000060);
    bus(`IDX_WINDOW_SCREEN_Y_END, 1'b1, 32'h00000011);
    bus(`IDX_WINDOW_SOURCE_X, 1'b1, 32'h00000100);
    bus(`IDX_WINDOW_SOURCE_Y, 1'b1, 32'h00000200);
    next_frame;
    capture(48'h040100040050, 48'h010200011011);
    $display("t_window done");
  endtask
  task t_slave;
    int i;
    bus(`IDX_CONTROL, 1'b1, 32'h00000006);
    for (i = 0; i < 100; i++) begin
      bus(`IDX_STATUS, 1'b0, 32'h0);
      if (rd[1] === 1'b0) break;
    end
    check(rd & 32'h2, 32'h0);
    bus(`IDX_HORIZ_SYNC_WIDTH, 1'b1, 32'h00000003);
    bus(`IDX_HORIZ_SCAN_DELAY, 1'b1, 32'h00000001);
    slave_period <= 8'h0A;
    bus(`IDX_CONTROL, 1'b1, 32'h00000005);
    next_frame;
    next_frame;
    check(32'(h_period), 32'hA);
    check(32'(h_width), 32'h3);
    for (i = 0; i < 200 && fetch_valid !== 1'b1; i++) @(posedge mclk);
    check(32'(horiz_sync), 32'h1);
    $display("t_slave done");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs;
    t_master;
    t_window;
    t_slave;
    wrap_up;
  end
endmodule // raster_timing_test
